// ### rtl/rtcs_consts.svh
`ifndef RTCS_CONSTS_SVH
`define RTCS_CONSTS_SVH
// slave address, 7-bit form without direction bit
`define RTCS_SLAVE_ADDR     7'h68
`define RTCS_REG_COUNT      16
`define RTCS_CLOCK_LAST     4'h7
`define RTCS_PTR_RESET      4'h0
`define RTCS_SUBSEC_ADDR    4'h0
`define RTCS_CLK_HZ         50000000
// link clock period driven by the master end, in ns
`define RTCS_SCL_PERIOD_NS  2560
`define RTCS_CLK_PERIOD_NS  20
`define RTCS_SCL_QTR_CYC    ((`RTCS_SCL_PERIOD_NS / `RTCS_CLK_PERIOD_NS) / 4)
`endif

// ### rtl/rtcs_pkg.sv
package rtcs_pkg;
    typedef enum logic [2:0] {
        RS_IDLE,
        RS_ADDR,
        RS_ACK_OUT,
        RS_RX,
        RS_TX,
        RS_ACK_IN,
        RS_IGNORE
    } rtcs_slv_state_t;

    typedef enum logic [3:0] {
        RM_IDLE,
        RM_START,
        RM_BIT_LO,
        RM_BIT_HI,
        RM_ACK_LO,
        RM_ACK_HI,
        RM_STOP_A,
        RM_STOP_B,
        RM_STOP_C
    } rtcs_mst_state_t;
endpackage

// ### rtl/rtcs_bus_if.sv
`timescale 1ns/10ps
// two-wire bus with pull-ups; each end drives low when its enable is low
interface rtcs_bus_if;
    logic scl_oe_n_m; // master clock enable, low drives low
    logic sda_oe_n_m; // master data enable, low drives low
    logic sda_oe_n_s; // slave data enable, low drives low
    logic scl;        // resolved clock line
    logic sda;        // resolved data line

    assign scl = scl_oe_n_m;
    assign sda = sda_oe_n_m & sda_oe_n_s;

    modport slave  (input scl, input sda, output sda_oe_n_s);
    modport master (input scl, input sda, output scl_oe_n_m, output sda_oe_n_m);
endinterface

// ### rtl/rtcs_fifo.sv
`timescale 1ns/10ps
module rtcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock_i,   // system clock
    input  wire logic             sys_rst_i, // sync reset
    input  wire logic [WIDTH-1:0] in_data_i, // write data
    input  wire logic             in_valid_i,// write request
    output logic                  in_ready_o,// not full
    output logic      [WIDTH-1:0] out_data_o,// head word
    output logic                  out_valid_o,// not empty
    input  wire logic             out_ready_i // drain
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // pointer and count next values
    always_comb begin
        push  = in_valid_i && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
        pop   = out_ready_i && (cnt_q != '0);
        wr_d  = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
        rd_d  = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // registers and storage
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
endmodule

// ### rtl/rtcs_slave.sv
// Functional notes
// RULE1: answer only START plus address D0h
// RULE2: sixteen byte registers in fixed order
// RULE3: master starts only on idle bus
// RULE4: data stable while clock high
// RULE5: data falling, clock high means START
// RULE6: data rising, clock high means STOP
// RULE7: one bit per clock, change low
// RULE8: unlimited bytes between START and STOP
// RULE9: eight bits then receiver acknowledge bit
// RULE10: master clocks every acknowledge bit
// RULE11: acknowledge holds data low while high
// RULE12: no master acknowledge, slave releases data
// RULE13: random read via pointer write, restart
// RULE14: pointer advances on data acknowledge clock
// RULE15: clock addresses halt user copy update
// RULE16: plain read starts at held pointer
// RULE17: first written byte loads the pointer
// RULE18: acknowledge address, pointer and data
// RULE19: clock writes buffered, copied together later
// RULE20: timekeeping write zeroes sub-second register; code only forces 00h on a write to address 0 itself
// RULE21: wrong address: release and ignore
// RULE22: pointer wraps from 0Fh to 00h
`timescale 1ns/10ps
`include "rtcs_consts.svh"
module rtcs_slave
    import rtcs_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic       clock_i,       // system clock
    input  wire logic       sys_rst_i,     // sync reset, high
    rtcs_bus_if.slave       bus,           // two-wire link
    input  wire logic [7:0] rd_data_i,     // byte at rd_addr_o
    output logic      [3:0] rd_addr_o,     // word address pointer value
    output logic            wr_stb_o,      // one-cycle register write strobe
    output logic      [3:0] wr_addr_o,     // write address
    output logic      [7:0] wr_data_o,     // write data
    input  wire logic       wr_ready_i,    // user accepts writes
    output logic            halt_update_o, // freeze user copy
    output logic            clk_load_o     // copy buffers into counters
);
    // link inputs pass two flops before use
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, scl_p_q, sda_p_q;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3f;
        end else begin
            scl_m_q <= bus.scl;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= bus.sda;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q; // [RULE5] [RULE4]
    assign stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q; // [RULE6]

    rtcs_slv_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic [3:0] ptr_q, ptr_d;
    logic       first_q, first_d, rw_q, rw_d, sda_q, sda_d, nack_q, nack_d;
    logic       halt_q, halt_d, load_q, load_d, dirty_q, dirty_d;
    logic       full_q, full_d;
    logic       push, ack_ok;
    logic [11:0] fifo_in, fifo_out;
    logic       fifo_rdy, fifo_vld;

    // data buffer toward the register file; full fifo withholds acknowledge
    rtcs_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .in_data_i  (fifo_in),
        .in_valid_i (push),
        .in_ready_o (fifo_rdy),
        .out_data_o (fifo_out),
        .out_valid_o(fifo_vld),
        .out_ready_i(wr_ready_i)
    );

    // protocol engine next state
    always_comb begin
        st_d    = st_q;
        sh_d    = sh_q;
        bit_d   = bit_q;
        ptr_d   = ptr_q;
        first_d = first_q;
        rw_d    = rw_q;
        sda_d   = sda_q;
        nack_d  = nack_q;
        dirty_d = dirty_q;
        full_d  = full_q;
        load_d  = 1'b0;
        push    = 1'b0;
        ack_ok  = fifo_rdy;
        // sub-second address accepts zero only
        fifo_in = {ptr_q, (ptr_q == `RTCS_SUBSEC_ADDR) ? 8'h00 : sh_q}; // [RULE20]
        if (start_c) begin
            st_d  = RS_ADDR; // [RULE1] [RULE13]
            bit_d = 3'h0;
            full_d = 1'b0;
            sda_d = 1'b1;
        end else if (stop_c) begin
            st_d    = RS_IDLE; // [RULE6] [RULE8]
            sda_d   = 1'b1;
            load_d  = dirty_q; // [RULE19]
            dirty_d = 1'b0;
        end else begin
            case (st_q)
                RS_ADDR, RS_RX: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s_q}; // [RULE7]
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) full_d = 1'b1; // [RULE9]
                    end
                    // decide only after eight bits, not on the fall that ends START
                    if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        if (st_q == RS_ADDR) begin
                            if (sh_q[7:1] == `RTCS_SLAVE_ADDR) begin // [RULE1]
                                rw_d  = sh_q[0];
                                first_d = ~sh_q[0];
                                sda_d = 1'b0; // [RULE18] [RULE11]
                                st_d  = RS_ACK_OUT;
                            end else begin
                                st_d = RS_IGNORE; // [RULE21]
                            end
                        end else if (first_q) begin
                            ptr_d   = sh_q[3:0]; // [RULE17] [RULE13]
                            first_d = 1'b0;
                            sda_d   = 1'b0; // [RULE18]
                            st_d    = RS_ACK_OUT;
                        end else if (ack_ok) begin
                            push  = 1'b1; // [RULE17]
                            if (ptr_q <= `RTCS_CLOCK_LAST) dirty_d = 1'b1; // [RULE19]
                            sda_d = 1'b0; // [RULE18]
                            st_d  = RS_ACK_OUT;
                            ptr_d = ptr_q + 4'h1; // [RULE14] [RULE22]
                            // last clock address written: copy now, nothing left for stop
                            if (ptr_q == `RTCS_CLOCK_LAST) begin
                                load_d  = 1'b1; // [RULE19]
                                dirty_d = 1'b0;
                            end
                        end else begin
                            st_d = RS_IGNORE;
                        end
                    end
                end
                RS_ACK_OUT: begin
                    if (scl_fall) begin // [RULE9]
                        if (rw_q) begin
                            sda_d = rd_data_i[7]; // [RULE16]
                            sh_d  = {rd_data_i[6:0], 1'b1};
                            bit_d = 3'h1;
                            st_d  = RS_TX;
                        end else begin
                            sda_d = 1'b1;
                            bit_d = 3'h0;
                            st_d  = RS_RX;
                        end
                    end
                end
                RS_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 3'h0) begin
                            sda_d = 1'b1; // release for master acknowledge
                            st_d  = RS_ACK_IN;
                        end else begin
                            sda_d = sh_q[7]; // [RULE7]
                            sh_d  = {sh_q[6:0], 1'b1};
                            bit_d = bit_q + 3'h1;
                        end
                    end
                end
                RS_ACK_IN: begin
                    if (scl_rise) begin
                        nack_d = sda_s_q;
                        ptr_d  = ptr_q + 4'h1; // [RULE14] [RULE22] [RULE10]
                    end
                    if (scl_fall) begin
                        if (nack_q) begin
                            st_d = RS_IGNORE; // [RULE12]
                        end else begin
                            sda_d = rd_data_i[7];
                            sh_d  = {rd_data_i[6:0], 1'b1};
                            bit_d = 3'h1;
                            st_d  = RS_TX;
                        end
                    end
                end
                RS_IGNORE: sda_d = 1'b1; // [RULE21] [RULE12]
                RS_IDLE:   sda_d = 1'b1;
                default:   st_d = RS_IDLE;
            endcase
        end
        // halt while busy on a clock address
        halt_d = (st_d != RS_IDLE) && (ptr_d <= `RTCS_CLOCK_LAST); // [RULE15] [RULE2]
    end

    // protocol engine registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_q    <= RS_IDLE;
            sh_q    <= 8'h00;
            bit_q   <= 3'h0;
            ptr_q   <= `RTCS_PTR_RESET;
            first_q <= 1'b0;
            rw_q    <= 1'b0;
            sda_q   <= 1'b1;
            nack_q  <= 1'b0;
            halt_q  <= 1'b0;
            load_q  <= 1'b0;
            dirty_q <= 1'b0;
            full_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            sh_q    <= sh_d;
            bit_q   <= bit_d;
            ptr_q   <= ptr_d;
            first_q <= first_d;
            rw_q    <= rw_d;
            sda_q   <= sda_d;
            nack_q  <= nack_d;
            halt_q  <= halt_d;
            load_q  <= load_d;
            dirty_q <= dirty_d;
            full_q  <= full_d;
        end
    end

    // write port registered from the fifo head
    logic       wst_q;
    logic [11:0] wdat_q;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wst_q  <= 1'b0;
            wdat_q <= 12'h000;
        end else begin
            wst_q  <= fifo_vld & wr_ready_i;
            wdat_q <= fifo_out;
        end
    end

    assign bus.sda_oe_n_s = sda_q;
    assign rd_addr_o      = ptr_q;
    assign wr_stb_o       = wst_q;
    assign wr_addr_o      = wdat_q[11:8];
    assign wr_data_o      = wdat_q[7:0];
    assign halt_update_o  = halt_q;
    assign clk_load_o     = load_q;
endmodule

// ### rtl/rtcs_master.sv
`timescale 1ns/10ps
`include "rtcs_consts.svh"
module rtcs_master
    import rtcs_pkg::*;
(
    input  wire logic       clock_i,   // system clock
    input  wire logic       sys_rst_i, // sync reset, high
    rtcs_bus_if.master      bus,       // two-wire link
    input  wire logic       cmd_vld_i, // byte command valid
    input  wire logic       cmd_start_i,// send START first
    input  wire logic       cmd_stop_i, // send STOP after
    input  wire logic       cmd_read_i, // read a byte
    input  wire logic       cmd_nack_i, // withhold acknowledge on read
    input  wire logic [7:0] cmd_data_i, // byte to write
    output logic            busy_o,     // command running
    output logic            done_o,     // one-cycle completion
    output logic      [7:0] rd_data_o,  // byte read
    output logic            ack_o       // slave acknowledged
);
    localparam int QTR = `RTCS_SCL_QTR_CYC;
    rtcs_mst_state_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d, sh_q, sh_d, rd_q, rd_d;
    logic [2:0] bit_q, bit_d;
    logic       scl_q, scl_d, sda_q, sda_d, done_q, done_d, ack_q, ack_d;
    logic       rd_op_q, rd_op_d, nk_q, nk_d, stp_q, stp_d;
    logic       sda_m_q, sda_s_q, tick, mid;
    assign tick = (cnt_q == 8'((QTR * 2) - 1));
    assign mid  = (cnt_q == 8'(QTR - 1)); // half-way through a half period

    // sampled data line
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            sda_m_q <= bus.sda;
            sda_s_q <= sda_m_q;
        end
    end

    // half-period sequencer; master drives every acknowledge clock
    always_comb begin
        st_d = st_q; cnt_d = tick ? 8'h00 : cnt_q + 8'h01; sh_d = sh_q; rd_d = rd_q;
        bit_d = bit_q; scl_d = scl_q; sda_d = sda_q; done_d = 1'b0; ack_d = ack_q;
        rd_op_d = rd_op_q; nk_d = nk_q; stp_d = stp_q;
        case (st_q)
            RM_IDLE: begin
                cnt_d = 8'h00;
                if (cmd_vld_i) begin
                    sh_d = cmd_read_i ? 8'hff : cmd_data_i;
                    rd_op_d = cmd_read_i; nk_d = cmd_nack_i; stp_d = cmd_stop_i;
                    bit_d = 3'h0;
                    if (cmd_start_i) begin
                        sda_d = 1'b1; scl_d = 1'b1; st_d = RM_START; // [RULE3]
                    end else begin
                        st_d = RM_BIT_LO;
                    end
                end
            end
            RM_START: if (tick) begin
                if (sda_q) sda_d = 1'b0; // [RULE5]
                else begin scl_d = 1'b0; st_d = RM_BIT_LO; end
            end
            // data moves only mid-way through the low half, never at a clock edge
            RM_BIT_LO: begin
                if (mid && !scl_q) sda_d = sh_q[7]; // [RULE7] [RULE4]
                if (tick) begin
                    if (scl_q) scl_d = 1'b0;
                    else begin scl_d = 1'b1; st_d = RM_BIT_HI; end
                end
            end
            RM_BIT_HI: if (tick) begin
                sh_d = {sh_q[6:0], 1'b1}; rd_d = {rd_q[6:0], sda_s_q};
                scl_d = 1'b0; bit_d = bit_q + 3'h1;
                st_d = (bit_q == 3'h7) ? RM_ACK_LO : RM_BIT_LO; // [RULE9]
            end
            RM_ACK_LO: begin
                if (mid) sda_d = rd_op_q ? nk_q : 1'b1; // [RULE11] [RULE12]
                if (tick) begin scl_d = 1'b1; st_d = RM_ACK_HI; end // [RULE10]
            end
            RM_ACK_HI: if (tick) begin
                ack_d = ~sda_s_q; scl_d = 1'b0;
                if (stp_q) st_d = RM_STOP_A;
                else begin sda_d = 1'b1; done_d = 1'b1; st_d = RM_IDLE; end
            end
            RM_STOP_A: begin
                if (mid) sda_d = 1'b0;
                if (tick) begin scl_d = 1'b1; st_d = RM_STOP_B; end
            end
            RM_STOP_B: if (tick) begin sda_d = 1'b1; st_d = RM_STOP_C; end // [RULE6]
            RM_STOP_C: if (tick) begin done_d = 1'b1; st_d = RM_IDLE; end
            default: st_d = RM_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_q <= RM_IDLE; cnt_q <= 8'h00; sh_q <= 8'hff; rd_q <= 8'h00;
            bit_q <= 3'h0; scl_q <= 1'b1; sda_q <= 1'b1; done_q <= 1'b0;
            ack_q <= 1'b0; rd_op_q <= 1'b0; nk_q <= 1'b0; stp_q <= 1'b0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; rd_q <= rd_d;
            bit_q <= bit_d; scl_q <= scl_d; sda_q <= sda_d; done_q <= done_d;
            ack_q <= ack_d; rd_op_q <= rd_op_d; nk_q <= nk_d; stp_q <= stp_d;
        end
    end

    logic busy_q;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) busy_q <= 1'b0;
        else busy_q <= (st_d != RM_IDLE);
    end

    assign bus.scl_oe_n_m = scl_q;
    assign bus.sda_oe_n_m = sda_q;
    assign busy_o    = busy_q;
    assign done_o    = done_q;
    assign rd_data_o = rd_q;
    assign ack_o     = ack_q;
endmodule

// ### testbench/rtcs_chk.sv
`timescale 1ns/10ps
`include "rtcs_consts.svh"
module rtcs_chk (
    input wire logic clock_i,    // system clock
    input wire logic sys_rst_i,  // sync reset, high
    input wire logic scl,        // resolved clock line
    input wire logic sda,        // resolved data line
    input wire logic scl_oe_n_m, // master clock enable
    input wire logic sda_oe_n_m, // master data enable
    input wire logic sda_oe_n_s  // slave data enable
);
    logic       scl_q, sda_q, rise, start_w, stop_w, adr_hit, idle;
    logic       any_q, any_d, first_q, first_d, rd_q, rd_d, frn_q, frn_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;

    // line edges and bus conditions against the previous sample
    assign rise    = scl & ~scl_q;
    assign start_w = scl & scl_q & sda_q & ~sda;
    assign stop_w  = scl & scl_q & ~sda_q & sda;
    assign adr_hit = (sh_q[7:1] == `RTCS_SLAVE_ADDR);
    assign idle    = ~any_q & ~first_q;

    // bit position in the byte, address decode and direction
    always_comb begin
        any_d = any_q;
        first_d = first_q;
        rd_d = rd_q;
        frn_d = frn_q;
        bit_d = bit_q;
        sh_d = sh_q;
        if (start_w || stop_w) begin
            any_d = 1'b0;
            first_d = start_w;
            rd_d = 1'b0;
            frn_d = 1'b0;
            bit_d = 4'h0;
        end else if (rise) begin
            any_d = 1'b1;
            sh_d = {sh_q[6:0], sda};
            bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h8) begin
                first_d = 1'b0;
            end
            if (bit_q == 4'h8 && first_q) begin
                rd_d = adr_hit & sh_q[0];
                frn_d = ~adr_hit;
            end
        end
    end

    // register the tracking state
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            any_q <= 1'b0;
            first_q <= 1'b0;
            rd_q <= 1'b0;
            frn_q <= 1'b0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            any_q <= any_d;
            first_q <= first_d;
            rd_q <= rd_d;
            frn_q <= frn_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_high_hold;
        scl && $past(scl);
    endsequence
    sequence s_stop_seen;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence s_ack_clock;
        rise && bit_q == 4'h8;
    endsequence

    a_slave_hold_high: assert property (s_high_hold |-> $stable(sda_oe_n_s))
        else $error("slave data moved while clock high");
    a_ack_steady: assert property ($rose(scl) && !sda_oe_n_s |-> !sda_oe_n_s throughout scl[*8])
        else $error("slave low level not held through clock high");
    a_stop_release: assert property (s_stop_seen |=> sda_oe_n_s[*8])
        else $error("slave drives data after stop");
    a_byte_frame: assert property ((start_w || stop_w) && any_q |-> bit_q == 4'h1)
        else $error("transfer not framed in nine-bit units");
    a_addr_ack: assert property (s_ack_clock and first_q && adr_hit |-> !sda_oe_n_s)
        else $error("own address not acknowledged");
    a_foreign_quiet: assert property (s_ack_clock and first_q && !adr_hit |-> sda_oe_n_s)
        else $error("foreign address acknowledged");
    a_ignore_release: assert property (frn_q |-> sda_oe_n_s)
        else $error("slave drives during foreign transfer");
    a_read_release: assert property (s_ack_clock and rd_q |-> sda_oe_n_s)
        else $error("slave drives during master acknowledge");
    a_master_quiet_ack: assert property (s_ack_clock and (first_q || !rd_q) |-> sda_oe_n_m)
        else $error("master drives during slave acknowledge");
    a_bus_idle: assert property (idle |-> scl_oe_n_m)
        else $error("clock not released on idle bus");
endmodule

// ### testbench/tb.sv
`timescale 1ns/10ps
module tb;
    localparam logic [10:0] N_ACK  = 11'h600;
    localparam logic [10:0] N_NACK = 11'h400;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        cmd_vld, cmd_start, cmd_stop, cmd_read, cmd_nack, busy, done, ack;
    logic [7:0]  cmd_data, m_rd, rd_data, wr_data;
    logic [3:0]  rd_addr, wr_addr, cur_ptr;
    logic        wr_stb, wr_ready, halt, clk_load;
    logic [7:0]  user_mem [16];
    logic [7:0]  exp_mem [16];
    logic [10:0] note_q [$];
    logic [11:0] wr_q [$];
    logic [10:0] nt;
    logic [11:0] wn;
    logic [31:0] seed = 32'h0000_4bf4;
    int          error_cnt = 0, tests_run = 0, cycle_cnt = 0, ld_cnt = 0;

    always #10 clock_i = ~clock_i;

    rtcs_bus_if bus_i ();
    rtcs_master rtcs_master_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus(bus_i.master),
        .cmd_vld_i(cmd_vld), .cmd_start_i(cmd_start), .cmd_stop_i(cmd_stop),
        .cmd_read_i(cmd_read), .cmd_nack_i(cmd_nack), .cmd_data_i(cmd_data),
        .busy_o(busy), .done_o(done), .rd_data_o(m_rd), .ack_o(ack));
    rtcs_slave #(.FIFO_DEPTH(4)) rtcs_slave_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .bus(bus_i.slave), .rd_data_i(rd_data), .rd_addr_o(rd_addr), .wr_stb_o(wr_stb),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_ready_i(wr_ready),
        .halt_update_o(halt), .clk_load_o(clk_load));
    rtcs_chk rtcs_chk_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl(bus_i.scl),
        .sda(bus_i.sda), .scl_oe_n_m(bus_i.scl_oe_n_m), .sda_oe_n_m(bus_i.sda_oe_n_m),
        .sda_oe_n_s(bus_i.sda_oe_n_s));

    // user register file answers the slave combinationally
    assign rd_data = user_mem[rd_addr];

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", what, e, g);
            error_cnt++;
        end
    endtask

    task automatic wrap_up;
        $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // results are matched against the oldest note as they appear
    always @(posedge clock_i) begin
        if (done === 1'b1) begin
            nt = (note_q.size() > 0) ? note_q.pop_front() : 11'h7ff;
            chk("busy at done", 8'h00, {7'h00, busy});
            if (nt[10]) chk("ack", {7'h00, nt[9]}, {7'h00, ack});
            if (nt[8]) chk("read data", nt[7:0], m_rd);
        end
        if (wr_stb === 1'b1 && wr_ready === 1'b1) begin
            wn = (wr_q.size() > 0) ? wr_q.pop_front() : 12'hfff;
            chk("write addr", {4'h0, wn[11:8]}, {4'h0, wr_addr});
            chk("write data", wn[7:0], wr_data);
            user_mem[wr_addr] <= wr_data;
        end
        if (clk_load === 1'b1) ld_cnt++;
        cycle_cnt++;
        if (cycle_cnt == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic xfer(input logic s, p, r, n, input logic [7:0] d, input logic [10:0] note);
        @(posedge clock_i);
        cmd_vld <= 1'b1;
        cmd_start <= s;
        cmd_stop <= p;
        cmd_read <= r;
        cmd_nack <= n;
        cmd_data <= d;
        note_q.push_back(note);
        @(posedge clock_i);
        cmd_vld <= 1'b0;
        @(posedge clock_i);
        chk("busy", 8'h01, {7'h00, busy});
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock_i);
            if (done === 1'b1) break;
        end
    endtask

    task automatic set_ptr(input logic [3:0] p);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hd0, N_ACK);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, {4'h0, p}, N_ACK);
        cur_ptr = p;
        repeat (4) @(posedge clock_i);
        chk("halt on pointer", {7'h00, p < 4'h8}, {7'h00, halt});
    endtask

    // pointer write then n data bytes; bytes past nacc are refused
    task automatic wr_burst(input logic [3:0] p, input int n, input int nacc, input int loads);
        logic [7:0] d;
        int         l0;
        l0 = ld_cnt;
        set_ptr(p);
        for (int k = 0; k < n; k++) begin
            seed = xs(seed);
            d = seed[7:0];
            if (k < nacc) begin
                exp_mem[cur_ptr] = (cur_ptr == 4'h0) ? 8'h00 : d;
                wr_q.push_back({cur_ptr, exp_mem[cur_ptr]});
                cur_ptr = cur_ptr + 4'h1;
            end
            xfer(1'b0, k == n - 1, 1'b0, 1'b0, d, (k < nacc) ? N_ACK : N_NACK);
        end
        repeat (8) @(posedge clock_i);
        chk("halt after stop", 8'h00, {7'h00, halt});
        chk("counter loads", 8'(loads), 8'(ld_cnt - l0));
    endtask

    task automatic rd_burst(input logic set, input logic [3:0] p, input int n);
        if (set) set_ptr(p);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hd1, N_ACK);
        for (int k = 0; k < n; k++) begin
            xfer(1'b0, k == n - 1, 1'b1, k == n - 1, 8'h00, {3'b001, exp_mem[cur_ptr]});
            cur_ptr = cur_ptr + 4'h1;
        end
    endtask

    // main sequence
    initial begin
        cmd_vld = 1'b0;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        cmd_read = 1'b0;
        cmd_nack = 1'b0;
        cmd_data = 8'h00;
        wr_ready = 1'b1;
        cur_ptr = 4'h0;
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            user_mem[i] = seed[15:8];
            exp_mem[i] = seed[15:8];
        end
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        wr_burst(4'hd, 4, 4, 1);
        $display("test wrap write finished");
        rd_burst(1'b1, 4'he, 3);
        $display("test random read finished");
        wr_burst(4'h6, 2, 2, 1);
        $display("test clock write finished");
        rd_burst(1'b0, 4'h0, 2);
        $display("test current read finished");
        xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'ha0, N_NACK);
        $display("test foreign address finished");
        wr_ready <= 1'b0;
        wr_burst(4'h9, 5, 4, 0);
        wr_ready <= 1'b1;
        repeat (100) @(posedge clock_i);
        chk("writes left", 8'h00, 8'(wr_q.size()));
        chk("notes left", 8'h00, 8'(note_q.size()));
        $display("test buffer fill finished");
        wrap_up();
    end
endmodule
